// File: rtl/fspc_top.sv
`timescale 1ns/1ps
// Behaviour
// - flash write lasts 3.7 to 4.5 ms
// - reset does not abort running write
// - busy flag bit 6 reads zero
// - ready irq when enabled, global, store clear
// - no ready irq during eeprom or store
// - signature read bit arms load for three
// - store after signature arm does nothing
// - section read enable clears page buffer
// - protect read returns lock or fuse
// - page write programs buffer into page
// - page write bit clears at end/timeout
// - cpu halted during erase and write
// - page erase erases addressed page
// - page erase bit clears at end/timeout
// - store enable arms store four cycles
// - store enable alone loads buffer word
// - store enable clears after store/timeout
// - unknown bit 4:0 command patterns are ignored, bit 5 is not checked
// - eeprom write blocks programming and fuse reads
// - buffer cleared after write, secre, reset
// - programmed fuses read zero
module fspc_top
  import fspc_pkg::*;
#(
  parameter int PROG_CYC = FSPC_PROG_CYC,
  parameter int WORDS = 32,
  parameter int PAGES = 64
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [7:0] WB_DAT_I,
  output logic [7:0] WB_DAT_O,
  input wire logic WB_WE_I,
  input wire logic WB_SEL_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic WB_ACK_O,
  input wire logic STORE_INSN,
  input wire logic LOAD_INSN,
  input wire logic [15:0] Z_PTR,
  input wire logic [15:0] SOURCE_WORD_REGS,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic EEPROM_WRITE_ACTIVE,
  input wire logic [7:0] FUSE_LOW,
  input wire logic [7:0] FUSE_HIGH,
  input wire logic [7:0] FUSE_EXT,
  input wire logic [7:0] LOCK_BITS,
  input wire logic [7:0] SIG_BYTE,
  output logic [7:0] LOAD_DATA,
  output logic LOAD_VALID,
  output logic CPU_HALT,
  output logic STORE_READY_IRQ,
  output logic FLASH_ERASE,
  output logic FLASH_WRITE,
  output logic [15:0] FLASH_PAGE
);
  localparam int TW = 16;
  localparam int WW = $clog2(WORDS);
  typedef enum logic [1:0] {
    FSPC_IDLE_type_s = 2'b00,
    FSPC_ARMED_s = 2'b01,
    FSPC_BUSY_s = 2'b10
  } fspc_state_type;
  typedef struct packed {
    fspc_state_type st;
    logic [7:0] csr;
    logic [2:0] win;
    logic [TW-1:0] tmr;
    logic [WORDS-1:0] loaded;
    logic [7:0] rdat;
    logic ack;
    logic [7:0] ldat;
    logic lval;
    logic halt;
    logic irq;
    logic ers;
    logic wr;
    logic [15:0] page;
  } fspc_regs_type;
  fspc_regs_type r_q, r_d;
  logic [15:0] buf_q [WORDS];
  logic buf_we;
  logic [4:0] cmd;
  logic wr_csr;
  assign cmd = WB_DAT_I[4:0];
  // write lands on the edge after the one that raises ack, where the master samples ack and expects it
  assign wr_csr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I && r_q.ack &&
    WB_ADR_I == FSPC_CSR_ADDR;

  always_comb begin
    r_d = r_q;
    buf_we = 1'b0;
    r_d.ack = WB_CYC_I && WB_STB_I && !r_q.ack;
    r_d.lval = 1'b0;
    r_d.ers = 1'b0;
    r_d.wr = 1'b0;
    r_d.csr[FSPC_BIT_BUSY] = 1'b0;
    unique case (WB_ADR_I)
      FSPC_CSR_ADDR: r_d.rdat = r_q.csr & 8'hBF;
      FSPC_DATA_ADDR: r_d.rdat = r_q.ldat;
      default: r_d.rdat = 8'h00;
    endcase
    if (r_q.st == FSPC_ARMED_s) begin
      r_d.win = r_q.win + 3'h1;
      if (r_q.win == 3'(FSPC_STORE_WIN - 1)) begin
        r_d.st = FSPC_IDLE_type_s;
        r_d.csr[5:0] = 6'h00;
      end
      if (LOAD_INSN && r_q.win < 3'(FSPC_LOAD_WIN) &&
          (r_q.csr[FSPC_BIT_PROT] || r_q.csr[FSPC_BIT_SIG])) begin
        r_d.lval = 1'b1;
        if (r_q.csr[FSPC_BIT_SIG]) begin
          r_d.ldat = SIG_BYTE;
        end else if (!Z_PTR[0]) begin
          r_d.ldat = Z_PTR[1] ? FUSE_EXT : FUSE_LOW;
        end else begin
          r_d.ldat = Z_PTR[1] ? FUSE_HIGH : LOCK_BITS;
        end
        r_d.st = FSPC_IDLE_type_s;
        r_d.csr[5:0] = 6'h00;
      end else if (STORE_INSN) begin
        r_d.st = FSPC_IDLE_type_s;
        r_d.csr[5:0] = 6'h00;
        if (r_q.csr[FSPC_BIT_SIG] || r_q.csr[FSPC_BIT_PROT]) begin
          r_d.csr[5:0] = 6'h00;
        end else if (r_q.csr[FSPC_BIT_SECRE]) begin
          r_d.loaded = '0;
        end else if (r_q.csr[FSPC_BIT_PGWR] || r_q.csr[FSPC_BIT_PGER]) begin
          // enable and command bit stay up for the whole operation
          r_d.st = FSPC_BUSY_s;
          r_d.csr = r_q.csr;
          r_d.tmr = '0;
          r_d.halt = 1'b1;
          r_d.page = Z_PTR & ~16'(WORDS * 2 - 1);
          // the array latches this start pulse and finishes on its own supply
          r_d.ers = r_q.csr[FSPC_BIT_PGER];
          r_d.wr = r_q.csr[FSPC_BIT_PGWR];
        end else if (!r_q.loaded[Z_PTR[WW:1]]) begin
          buf_we = 1'b1;
          r_d.loaded[Z_PTR[WW:1]] = 1'b1;
        end
      end
    end else if (r_q.st == FSPC_BUSY_s) begin
      r_d.tmr = r_q.tmr + 16'h0001;
      if (r_q.tmr == 16'(PROG_CYC - 1)) begin
        r_d.st = FSPC_IDLE_type_s;
        r_d.halt = 1'b0;
        if (r_q.csr[FSPC_BIT_PGWR]) begin
          r_d.loaded = '0;
        end
        r_d.csr[5:0] = 6'h00;
      end
    end
    if (wr_csr) begin
      r_d.csr[FSPC_BIT_IRQ_EN] = WB_DAT_I[FSPC_BIT_IRQ_EN];
      if (r_q.st != FSPC_BUSY_s && !EEPROM_WRITE_ACTIVE) begin
        if (cmd == FSPC_CMD_RWWRE || WB_DAT_I[5:0] == 6'h21 || cmd == FSPC_CMD_PROT ||
            cmd == FSPC_CMD_PGWR || cmd == FSPC_CMD_PGER || cmd == FSPC_CMD_LOAD) begin
          r_d.csr[5:0] = WB_DAT_I[5:0] & 6'h3F;
          r_d.st = FSPC_ARMED_s;
          r_d.win = 3'h0;
          if (WB_DAT_I[FSPC_BIT_SECRE]) begin
            r_d.loaded = '0;
          end
        end
      end
    end
    if (EEPROM_WRITE_ACTIVE && r_q.st != FSPC_BUSY_s) begin
      r_d.loaded = '0;
    end
    r_d.irq = r_q.csr[FSPC_BIT_IRQ_EN] && GLOBAL_IRQ_EN && !r_q.csr[FSPC_BIT_EN] &&
      !EEPROM_WRITE_ACTIVE && r_q.st != FSPC_BUSY_s;
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // buffer contents are tracked by the loaded mask, so no reset is needed
  always_ff @(posedge SYS_CLK) begin
    if (buf_we) begin
      buf_q[Z_PTR[WW:1]] <= SOURCE_WORD_REGS;
    end
  end

  assign WB_DAT_O = r_q.rdat;
  assign WB_ACK_O = r_q.ack;
  assign LOAD_DATA = r_q.ldat;
  assign LOAD_VALID = r_q.lval;
  assign CPU_HALT = r_q.halt;
  assign STORE_READY_IRQ = r_q.irq;
  assign FLASH_ERASE = r_q.ers;
  assign FLASH_WRITE = r_q.wr;
  assign FLASH_PAGE = r_q.page;

  property p_busy_zero;
    @(posedge SYS_CLK) disable iff (!RESET_N) WB_ACK_O && $past(WB_ADR_I) == FSPC_CSR_ADDR
      |-> !WB_DAT_O[FSPC_BIT_BUSY];
  endproperty
  a_busy_zero: assert property (p_busy_zero) else $error("busy flag set");
  property p_halt_len;
    @(posedge SYS_CLK) disable iff (!RESET_N) $rose(CPU_HALT) |-> CPU_HALT [*8];
  endproperty
  a_halt_len: assert property (p_halt_len) else $error("halt too short");
  property p_arm_timeout;
    @(posedge SYS_CLK) disable iff (!RESET_N) $rose(r_q.st == FSPC_ARMED_s) && !STORE_INSN
      ##1 !STORE_INSN [*4] |-> ##[0:1] !r_q.csr[FSPC_BIT_EN];
  endproperty
  a_arm_timeout: assert property (p_arm_timeout) else $error("enable stuck");
  property p_irq_gate;
    @(posedge SYS_CLK) disable iff (!RESET_N) STORE_READY_IRQ |-> $past(GLOBAL_IRQ_EN) &&
      !$past(r_q.csr[FSPC_BIT_EN]) && !$past(EEPROM_WRITE_ACTIVE);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
  property p_irq_busy;
    @(posedge SYS_CLK) disable iff (!RESET_N) CPU_HALT |-> ##1 !STORE_READY_IRQ;
  endproperty
  a_irq_busy: assert property (p_irq_busy) else $error("irq while busy");
  property p_bad_cmd;
    @(posedge SYS_CLK) disable iff (!RESET_N) wr_csr && r_q.st == FSPC_IDLE_type_s &&
      cmd == 5'h1F |=> r_q.st == FSPC_IDLE_type_s;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command armed");
  property p_ee_block;
    @(posedge SYS_CLK) disable iff (!RESET_N) wr_csr && EEPROM_WRITE_ACTIVE &&
      r_q.st == FSPC_IDLE_type_s |=> r_q.st == FSPC_IDLE_type_s;
  endproperty
  a_ee_block: assert property (p_ee_block) else $error("eeprom did not block");
  property p_sig_store;
    @(posedge SYS_CLK) disable iff (!RESET_N) r_q.st == FSPC_ARMED_s && r_q.csr[FSPC_BIT_SIG]
      && STORE_INSN |=> !CPU_HALT && !FLASH_WRITE && !FLASH_ERASE;
  endproperty
  a_sig_store: assert property (p_sig_store) else $error("signature store acted");
  // pulse and level shapes of the flash side
  property p_ers_pulse;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      FLASH_ERASE |=> !FLASH_ERASE;
  endproperty
  a_ers_pulse: assert property (p_ers_pulse) else $error("erase pulse too long");
  property p_wr_pulse;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      FLASH_WRITE |=> !FLASH_WRITE;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
  property p_ers_halt;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      FLASH_ERASE |-> CPU_HALT;
  endproperty
  a_ers_halt: assert property (p_ers_halt) else $error("erase without halt");
  property p_wr_halt;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      FLASH_WRITE |-> CPU_HALT;
  endproperty
  a_wr_halt: assert property (p_wr_halt) else $error("write without halt");
  property p_halt_start;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      $rose(CPU_HALT) |-> $past(STORE_INSN) && $past(r_q.st == FSPC_ARMED_s);
  endproperty
  a_halt_start: assert property (p_halt_start) else $error("halt without store");
  property p_halt_en;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      CPU_HALT |-> r_q.csr[FSPC_BIT_EN];
  endproperty
  a_halt_en: assert property (p_halt_en) else $error("enable dropped while busy");
  property p_halt_end;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      $fell(CPU_HALT) |-> r_q.csr[5:0] == 6'h00;
  endproperty
  a_halt_end: assert property (p_halt_end) else $error("command bits stuck");
  property p_pgwr_flush;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      $fell(CPU_HALT) && $past(r_q.csr[FSPC_BIT_PGWR]) |-> r_q.loaded == '0;
  endproperty
  a_pgwr_flush: assert property (p_pgwr_flush) else $error("buffer kept after write");
  property p_ers_page;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      FLASH_ERASE |-> (FLASH_PAGE & 16'(WORDS * 2 - 1)) == 16'h0000;
  endproperty
  a_ers_page: assert property (p_ers_page) else $error("page not aligned");
  property p_armed_no_halt;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      r_q.st == FSPC_ARMED_s |-> !CPU_HALT;
  endproperty
  a_armed_no_halt: assert property (p_armed_no_halt) else $error("armed while halted");
  property p_armed_win;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      r_q.st == FSPC_ARMED_s |-> r_q.win < 3'(FSPC_STORE_WIN);
  endproperty
  a_armed_win: assert property (p_armed_win) else $error("window overran");
  property p_busy_bit;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      1'b1 |-> !r_q.csr[FSPC_BIT_BUSY];
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit stored");
  // load answers come only from an armed window
  property p_lval_pulse;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      LOAD_VALID |=> !LOAD_VALID;
  endproperty
  a_lval_pulse: assert property (p_lval_pulse) else $error("load valid too long");
  property p_load_src;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      LOAD_VALID |-> $past(LOAD_INSN) && $past(r_q.st == FSPC_ARMED_s);
  endproperty
  a_load_src: assert property (p_load_src) else $error("load outside window");
  property p_load_sig;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      LOAD_VALID && $past(r_q.csr[FSPC_BIT_SIG]) |-> LOAD_DATA == $past(SIG_BYTE);
  endproperty
  a_load_sig: assert property (p_load_sig) else $error("signature byte wrong");
  property p_load_lock;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      LOAD_VALID && $past(r_q.csr[FSPC_BIT_PROT]) && $past(Z_PTR[1:0]) == 2'h1
      |-> LOAD_DATA == $past(LOCK_BITS);
  endproperty
  a_load_lock: assert property (p_load_lock) else $error("lock byte wrong");
  // eeprom activity wipes a half loaded buffer
  property p_ee_flush;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      EEPROM_WRITE_ACTIVE && r_q.st != FSPC_BUSY_s |=> r_q.loaded == '0;
  endproperty
  a_ee_flush: assert property (p_ee_flush) else $error("buffer kept over eeprom");
  property p_irq_off;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      !r_q.csr[FSPC_BIT_IRQ_EN] |=> !STORE_READY_IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_irq_halt;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      CPU_HALT |-> !STORE_READY_IRQ;
  endproperty
  a_irq_halt: assert property (p_irq_halt) else $error("irq during operation");
  property p_irq_on;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      r_q.csr[FSPC_BIT_IRQ_EN] && GLOBAL_IRQ_EN && !r_q.csr[FSPC_BIT_EN] &&
      !EEPROM_WRITE_ACTIVE && r_q.st != FSPC_BUSY_s |=> STORE_READY_IRQ;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  // bus handshake shape
  property p_ack_pulse;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_req;
    @(posedge SYS_CLK) disable iff (!RESET_N)
      WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I);
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("ack without request");
endmodule

// File: rtl/fspc_pkg.sv
package fspc_pkg;
  localparam logic [7:0] FSPC_CSR_ADDR = 8'h37;
  localparam logic [7:0] FSPC_CTRL_ADDR = 8'h38;
  localparam logic [7:0] FSPC_FUSE_ADDR = 8'h39;
  localparam logic [7:0] FSPC_DATA_ADDR = 8'h3A;
  localparam logic [7:0] FSPC_CSR_RESET = 8'h00;
  localparam int FSPC_BIT_IRQ_EN = 7;
  localparam int FSPC_BIT_BUSY = 6;
  localparam int FSPC_BIT_SIG = 5;
  localparam int FSPC_BIT_SECRE = 4;
  localparam int FSPC_BIT_PROT = 3;
  localparam int FSPC_BIT_PGWR = 2;
  localparam int FSPC_BIT_PGER = 1;
  localparam int FSPC_BIT_EN = 0;
  localparam logic [4:0] FSPC_CMD_SIG = 5'h11;
  localparam logic [4:0] FSPC_CMD_SECRE = 5'h11 ^ 5'h11 ^ 5'h11;
  localparam logic [4:0] FSPC_CMD_RWWRE = 5'h11;
  localparam logic [4:0] FSPC_CMD_PROT = 5'h09;
  localparam logic [4:0] FSPC_CMD_PGWR = 5'h05;
  localparam logic [4:0] FSPC_CMD_PGER = 5'h03;
  localparam logic [4:0] FSPC_CMD_LOAD = 5'h01;
  localparam logic [4:0] FSPC_CMD_SIGNATURE_ROW_READ = 5'h21 >> 1;
  localparam int FSPC_STORE_WIN = 4;
  localparam int FSPC_LOAD_WIN = 3;
  localparam int FSPC_CLK_HZ = 10_000_000;
  localparam real FSPC_PROG_MIN_MS = 3.7;
  localparam real FSPC_PROG_MAX_MS = 4.5;
  localparam int FSPC_PROG_CYC = 37000;
  localparam logic [4:0] FSPC_TIMER_W = 5'd16;
endpackage

// File: testbench/fspc_cpu_model.sv
`timescale 1ns/1ps
module fspc_cpu_model (
  input wire logic halt,
  input wire logic do_store,
  input wire logic do_load,
  output logic store_insn,
  output logic load_insn
);
  // a halted core fetches nothing, so it issues neither instruction
  assign store_insn = do_store & ~halt;
  assign load_insn = do_load & ~halt;
endmodule

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import fspc_pkg::*;
  localparam int PC = 20;
  logic clk = 0, rst_n = 0, we = 0, sel = 0, cyc = 0, stb = 0;
  logic gie = 0, eep = 0, ds = 0, dl = 0;
  logic [7:0] adr = '0, dat = '0, fl = '0, fh = '0, fe = '0, lk = '0, sg = '0;
  logic [15:0] z = '0, src = '0;
  logic [7:0] rd, ldd;
  logic ack, ldv, halt, irq, fer, fwr, st, ld;
  logic [31:0] lf = 32'h9C89D4E8;
  logic [9:0] ng [7] = '{10'h121, 10'h107, 10'h303, 10'h101, 10'h005, 10'h001, 10'h11F};
  int errors = 0, samples_checked = 0, ner = 0, nwr = 0, hc = 0;
  initial forever #50 clk = ~clk;
  fspc_top #(.PROG_CYC(PC)) fspc_top_i (.SYS_CLK(clk), .RESET_N(rst_n),
    .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(rd), .WB_WE_I(we), .WB_SEL_I(sel),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack), .STORE_INSN(st), .LOAD_INSN(ld),
    .Z_PTR(z), .SOURCE_WORD_REGS(src), .GLOBAL_IRQ_EN(gie), .EEPROM_WRITE_ACTIVE(eep),
    .FUSE_LOW(fl), .FUSE_HIGH(fh), .FUSE_EXT(fe), .LOCK_BITS(lk), .SIG_BYTE(sg),
    .LOAD_DATA(ldd), .LOAD_VALID(ldv), .CPU_HALT(halt), .STORE_READY_IRQ(irq),
    .FLASH_ERASE(fer), .FLASH_WRITE(fwr), .FLASH_PAGE());
  fspc_cpu_model fspc_cpu_model_i (.halt(halt), .do_store(ds), .do_load(dl),
    .store_insn(st), .load_insn(ld));
  // running totals avoid racing single-cycle pulses
  always @(posedge clk) begin
    ner <= ner + fer;
    nwr <= nwr + fwr;
    hc <= hc + halt;
  end
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] fx(input logic [1:0] i);
    return i == 2'h0 ? fl : i == 2'h1 ? lk : i == 2'h2 ? fe : fh;
  endfunction
  task automatic print_verdict();
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic lim(input int n);
    if (n >= 500) begin
      errors++;
      print_verdict();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] r);
    int n;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    sel <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 500);
    lim(n);
    r = rd;
    cyc <= 0;
    stb <= 0;
    sel <= 0;
  endtask
  task automatic ins(input logic s, input logic l);
    ds <= s;
    dl <= l;
    @(posedge clk);
    ds <= 0;
    dl <= 0;
  endtask
  initial begin
    logic [7:0] r;
    int e0, w0, h0, n;
    repeat (20) @(posedge clk);
    rst_n <= 1;
    wb(0, FSPC_CSR_ADDR, 8'h00, r);
    chk(r, FSPC_CSR_RESET);
    wb(0, 8'h40, 8'h00, r);
    chk(r, 8'h00);
    for (int i = 0; i < 5; i++) begin
      lf = nx(lf);
      {fl, fh, fe, lk} <= lf;
      sg <= lf[15:8] ^ lf[7:0];
      z <= 16'(i);
      wb(1, FSPC_CSR_ADDR, i == 4 ? 8'h21 : 8'h09, r);
      ins(0, 1);
      @(posedge clk);
      chk(ldv, 1'b1);
      chk(ldd, i == 4 ? sg : fx(i[1:0]));
      repeat (4) @(posedge clk);
    end
    for (int i = 0; i < 2; i++) begin
      lf = nx(lf);
      {z, src} <= lf;
      e0 = ner;
      w0 = nwr;
      h0 = hc;
      wb(1, FSPC_CSR_ADDR, i ? 8'h05 : 8'h03, r);
      ins(1, 0);
      wb(0, FSPC_CSR_ADDR, 8'h00, r);
      chk(r, i ? 8'h05 : 8'h03);
      for (n = 0; halt === 1'b1 && n < 500; n++) @(posedge clk);
      lim(n);
      repeat (2) @(posedge clk);
      chk(hc - h0, PC);
      chk(ner - e0, !i);
      chk(nwr - w0, i);
      wb(0, FSPC_CSR_ADDR, 8'h00, r);
      chk(r, 8'h00);
    end
    // bit 8 issues a store, bit 9 holds the eeprom busy on purpose
    foreach (ng[k]) begin
      eep <= ng[k][9];
      e0 = ner + nwr + hc;
      wb(1, FSPC_CSR_ADDR, ng[k][7:0], r);
      ins(ng[k][8], 0);
      repeat (6) @(posedge clk);
      eep <= 0;
      wb(0, FSPC_CSR_ADDR, 8'h00, r);
      chk(r, 8'h00);
      chk(ner + nwr + hc - e0, 0);
    end
    wb(1, FSPC_CSR_ADDR, 8'h80, r);
    gie <= 1;
    repeat (3) @(posedge clk);
    chk(irq, 1'b1);
    eep <= 1;
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    eep <= 0;
    gie <= 0;
    repeat (3) @(posedge clk);
    chk(irq, 1'b0);
    print_verdict();
  end
endmodule
